// *** verilog/synth_ctrl_device.sv ***
// Synthesizer control register bank, serial slave end
`include "synth_ctrl_cfg.svh"
`default_nettype none
module synth_ctrl_device
  import synth_ctrl_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  synth_link_if.device     link,
  input  wire logic        compareTick,
  input  wire logic        phaseSmall,
  input  wire logic        nDivOut,
  input  wire logic        rDivOut,
  input  wire logic        analogLock,
  output logic [13:0]      refDivide,
  output logic [12:0]      progCount,
  output logic [5:0]       swallowCount,
  output logic [6:0]       prescalerModulus,
  output logic [2:0]       pumpCode,
  output logic [3:0]       pumpScale,
  output logic             dividerClear,
  output logic             poweredDown,
  output logic             lockDetect,
  output logic             lock_out_mux
);

  dev_state_s s_q;
  dev_state_s s_d;

  logic       clkRise;
  logic       strRise;
  logic       fastMode;
  logic       pdnHigh;
  logic [1:0] frameAddr;
  word_t      frameWord;

  function automatic logic [4:0] lockLimit(input logic depth, input logic isLocked);
    logic [4:0] lim;
    lim = 5'h00;
    if (isLocked) begin
      lim = depth ? `UNLOCK_LONG : `UNLOCK_SHORT;
    end else begin
      lim = depth ? `LOCK_LONG : `LOCK_SHORT;
    end
    return lim;
  endfunction

  function automatic logic [6:0] modulusOf(input logic [1:0] pre);
    logic [6:0] p;
    p = 7'h08 << pre;
    return p;
  endfunction

  function automatic logic [5:0] fastSpan(input logic [3:0] code);
    logic [5:0] n;
    n = 6'({code, 2'b00}) + `FAST_BASE;
    return n;
  endfunction

  // Edges of synchronised link lines
  assign clkRise   = s_q.clkSy[1] & ~s_q.clkSy[2];
  assign strRise   = s_q.strSy[1] & ~s_q.strSy[2];
  assign pdnHigh   = s_q.pdnSy[1];
  assign frameAddr = s_q.shift[1:0];
  assign frameWord = s_q.shift[`FRAME_MSB:2];
  assign fastMode  = s_q.funWord[`FAST_MSB:`FAST_LSB] == `FAST_ON;

  always_comb begin
    s_d = s_q;
    s_d.clkSy = {s_q.clkSy[1:0], link.sclk};
    s_d.strSy = {s_q.strSy[1:0], link.latch_strobe};
    s_d.datSy = {s_q.datSy[0], link.sdata};
    s_d.pdnSy = {s_q.pdnSy[0], link.shutdown_pin_n};

    // Shift in MSB first, select code last
    if (clkRise) begin
      s_d.shift = {s_q.shift[`FRAME_MSB-1:0], s_q.datSy[1]};
    end

    // Fast-lock switchover timer
    if (s_q.fastRun) begin
      if (!fastMode) begin
        s_d.fastRun = 1'b0;
      end else if (compareTick) begin
        if (s_q.fastCnt == 6'h01) begin
          s_d.fastRun = 1'b0;
          s_d.cntWord[`CNT_SEL_BIT] = 1'b0;
        end else begin
          s_d.fastCnt = s_q.fastCnt - 6'h01;
        end
      end
    end

    // Latch word on strobe edge, whatever the shutdown pin
    if (strRise) begin
      unique case (frameAddr)
        `ADDR_REF: begin
          s_d.refWord = frameWord;
        end
        `ADDR_CNT: begin
          s_d.cntWord = frameWord;
          s_d.locked  = 1'b0;
          s_d.runCnt  = 5'h00;
          s_d.fastRun = frameWord[`CNT_SEL_BIT] & fastMode;
          s_d.fastCnt = fastSpan(s_q.funWord[`TMR_MSB:`TMR_LSB]);
        end
        `ADDR_FUN: begin
          s_d.funWord = frameWord;
        end
        default: begin
        end
      endcase
    end

    // Power-down request from the function word
    if (!s_q.funWord[`SREQ_BIT]) begin
      s_d.sleeping = 1'b0;
    end else if (!s_q.funWord[`SSEL_BIT]) begin
      s_d.sleeping = 1'b1;
    end else if (compareTick) begin
      s_d.sleeping = 1'b1;
    end

    // Digital lock detect
    if (dividerClear || poweredDown) begin
      s_d.locked = 1'b0;
      s_d.runCnt = 5'h00;
    end else if (compareTick) begin
      if (phaseSmall != s_q.locked) begin
        if (s_q.runCnt + 5'h01 == lockLimit(s_q.refWord[`REF_DEPTH_BIT], s_q.locked)) begin
          s_d.locked = ~s_q.locked;
          s_d.runCnt = 5'h00;
        end else begin
          s_d.runCnt = s_q.runCnt + 5'h01;
        end
      end else begin
        s_d.runCnt = 5'h00;
      end
    end

    // Lock pin source select
    unique case (s_q.funWord[`LD_MSB:`LD_LSB])
      `LD_LOW:     s_d.lockPin = 1'b0;
      `LD_DIGITAL: s_d.lockPin = s_q.locked;
      `LD_NDIV:    s_d.lockPin = nDivOut;
      `LD_HIGH:    s_d.lockPin = 1'b1;
      `LD_RDIV:    s_d.lockPin = rDivOut;
      `LD_ANALOG:  s_d.lockPin = analogLock;
      default:     s_d.lockPin = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign refDivide        = s_q.refWord[`REF_DIV_MSB:0];
  assign progCount        = s_q.cntWord[`PROG_MSB:`PROG_LSB];
  assign swallowCount     = s_q.cntWord[`SWAL_MSB:0];
  assign prescalerModulus = modulusOf(s_q.funWord[`PRE_MSB:`PRE_LSB]);

  // Pump current code selection
  always_comb begin
    if (!fastMode) begin
      pumpCode = s_q.cntWord[`CNT_SEL_BIT] ? s_q.funWord[`CP2_MSB:`CP2_LSB]
                                           : s_q.funWord[`CP1_MSB:`CP1_LSB];
    end else begin
      pumpCode = (s_q.cntWord[`CNT_SEL_BIT] && s_q.fastRun) ? s_q.funWord[`CP2_MSB:`CP2_LSB]
                                                           : s_q.funWord[`CP1_MSB:`CP1_LSB];
    end
  end

  assign pumpScale    = {1'b0, pumpCode} + 4'h1;
  assign dividerClear = s_q.funWord[`DCLR_BIT];
  assign poweredDown  = ~pdnHigh | s_q.sleeping;
  assign lockDetect   = s_q.locked;
  assign lock_out_mux = s_q.lockPin;

endmodule
`default_nettype wire

// *** verilog/synth_ctrl_cfg.svh ***
// Constants for the synthesizer control link, device end and host end
// Operation
// - Host clears reference word bits 21:19, 17:14
// - Host clears counter word bits 21, 20
// - Lock depth bit: 15/3 or 31/7 comparisons
// - Reference divider 14 bits, never zero
// - Host keeps comparison rate at most 55MHz; host logic does not check it, left to software
// - Fast mode off: select bit picks current
// - Fast mode on: second current only during switchover
// - Programmable counter 13 bits, at least 3
// - Swallow 6 bits, not above programmable counter
// - Prescaler field picks 8, 16, 32, 64
// - Host keeps prescaler output at most 125MHz; host logic does not check it, left to software
// - Shutdown pin low powers down; high runs
// - Both sleep bits: power down at comparison
// - Sync select clear: power down at strobe
// - Writes accepted while shutdown pin low
// - Pump current is unit times code plus one
// - Lock output after consecutive small/large errors
// - Switchover 3+4*code periods, then select clears
// - Divider clear bit holds counters in reset
`ifndef SYNTH_CTRL_CFG_SVH
`define SYNTH_CTRL_CFG_SVH
`define WORD_W        22
`define FRAME_W       24
`define FRAME_MSB     23
`define ADDR_REF      2'h0
`define ADDR_CNT      2'h1
`define ADDR_FUN      2'h2
`define REF_DIV_MSB   13
`define REF_DEPTH_BIT 18
`define CNT_SEL_BIT   19
`define CNT_RSV_MSB   21
`define CNT_RSV_LSB   20
`define PROG_MSB      18
`define PROG_LSB      6
`define SWAL_MSB      5
`define PRE_MSB       21
`define PRE_LSB       20
`define SSEL_BIT      19
`define CP2_MSB       18
`define CP2_LSB       16
`define CP1_MSB       15
`define CP1_LSB       13
`define TMR_MSB       12
`define TMR_LSB       9
`define FAST_MSB      8
`define FAST_LSB      7
`define LD_MSB        4
`define LD_LSB        2
`define SREQ_BIT      1
`define DCLR_BIT      0
`define REF_KEEP      22'h043fff
`define CNT_KEEP      22'h0fffff
`define FAST_ON       2'h3
`define LOCK_SHORT    5'h0f
`define LOCK_LONG     5'h1f
`define UNLOCK_SHORT  5'h03
`define UNLOCK_LONG   5'h07
`define FAST_BASE     6'h03
`define PROG_MIN      13'h0003
`define LD_LOW        3'h0
`define LD_DIGITAL    3'h1
`define LD_NDIV       3'h2
`define LD_HIGH       3'h3
`define LD_RDIV       3'h4
`define LD_ANALOG     3'h5
`define CORE_NS       50
`define SCLK_HALF_NS  200
`define SCLK_HALF_CYC 3'(((`SCLK_HALF_NS) + (`CORE_NS) - 1) / (`CORE_NS))
`define HOST_DATA     4'h0
`define HOST_CMD      4'h4
`define HOST_STAT     4'h8
`define CMD_GO_BIT    8
`define CMD_PDN_BIT   4
`define STAT_BUSY_BIT 0
`define STAT_ERR_BIT  1
`endif

// *** verilog/synth_ctrl_pkg.sv ***
// Types shared by the synthesizer control ends
`default_nettype none
package synth_ctrl_pkg;
  typedef enum logic [2:0] {
    H_IDLE  = 3'b001,
    H_SHIFT = 3'b010,
    H_LATCH = 3'b100
  } host_state_e;

  typedef logic [21:0] word_t;

  typedef struct packed {
    logic [2:0] clkSy;
    logic [2:0] strSy;
    logic [1:0] datSy;
    logic [1:0] pdnSy;
    logic [23:0] shift;
    word_t      refWord;
    word_t      cntWord;
    word_t      funWord;
    logic       locked;
    logic [4:0] runCnt;
    logic       fastRun;
    logic [5:0] fastCnt;
    logic       sleeping;
    logic       lockPin;
  } dev_state_s;

  typedef struct packed {
    host_state_e state;
    word_t       dataWord;
    logic [23:0] frame;
    logic [4:0]  bitIdx;
    logic [2:0]  halfCnt;
    logic        sclk;
    logic        strobe;
    logic        pdnLevel;
    logic [1:0]  lastAddr;
    logic        error;
    logic [31:0] rdata;
  } host_state_s;
endpackage
`default_nettype wire

// *** verilog/synth_link_if.sv ***
// Three-wire link plus shutdown pin between host and synthesizer
`default_nettype none
interface synth_link_if;
  logic sclk;
  logic sdata;
  logic latch_strobe;
  logic shutdown_pin_n;
  modport host (output sclk, output sdata, output latch_strobe, output shutdown_pin_n);
  modport device (input sclk, input sdata, input latch_strobe, input shutdown_pin_n);
endinterface
`default_nettype wire

// *** verilog/synth_ctrl_host.sv ***
// Host controller driving the three-wire synthesizer link
`include "synth_ctrl_cfg.svh"
`default_nettype none
module synth_ctrl_host
  import synth_ctrl_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  synth_link_if.host       link,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata
);

  host_state_s s_q;
  host_state_s s_d;

  logic [1:0] goAddr;
  logic       goReq;
  logic       wordBad;
  word_t      cleanWord;

  assign goAddr = wdata[1:0];
  assign goReq  = wr && addr == `HOST_CMD && wdata[`CMD_GO_BIT];

  // Reserved bits forced low; frequency limits stay with software
  always_comb begin
    cleanWord = s_q.dataWord;
    wordBad   = 1'b0;
    unique case (goAddr)
      `ADDR_REF: begin
        cleanWord = s_q.dataWord & `REF_KEEP;
        wordBad   = s_q.dataWord[`REF_DIV_MSB:0] == 14'h0000;
      end
      `ADDR_CNT: begin
        cleanWord = s_q.dataWord & `CNT_KEEP;
        wordBad   = s_q.dataWord[`PROG_MSB:`PROG_LSB] < `PROG_MIN
                 || s_q.dataWord[`PROG_MSB:`PROG_LSB] < 13'(s_q.dataWord[`SWAL_MSB:0]);
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.rdata = 32'h00000000;
    if (rd) begin
      unique case (addr)
        `HOST_DATA: s_d.rdata = 32'(s_q.dataWord);
        `HOST_CMD:  s_d.rdata = 32'({s_q.pdnLevel, 2'b00, s_q.lastAddr});
        `HOST_STAT: s_d.rdata = 32'({s_q.error, s_q.state != H_IDLE});
        default:    s_d.rdata = 32'h00000000;
      endcase
    end
    if (wr && addr == `HOST_DATA && s_q.state == H_IDLE) begin
      s_d.dataWord = wdata[`WORD_W-1:0];
    end
    if (wr && addr == `HOST_CMD) begin
      s_d.pdnLevel = wdata[`CMD_PDN_BIT];
    end
    if (wr && addr == `HOST_STAT && wdata[`STAT_ERR_BIT]) begin
      s_d.error = 1'b0;
    end

    unique case (s_q.state)
      H_IDLE: begin
        if (goReq) begin
          if (wordBad) begin
            s_d.error = 1'b1;
          end else begin
            s_d.frame    = {cleanWord, goAddr};
            s_d.lastAddr = goAddr;
            s_d.bitIdx   = 5'h00;
            s_d.halfCnt  = 3'h0;
            s_d.sclk     = 1'b0;
            s_d.state    = H_SHIFT;
          end
        end
      end
      H_SHIFT: begin
        if (s_q.halfCnt == `SCLK_HALF_CYC - 3'h1) begin
          s_d.halfCnt = 3'h0;
          s_d.sclk    = ~s_q.sclk;
          if (s_q.sclk) begin
            s_d.frame  = {s_q.frame[`FRAME_MSB-1:0], 1'b0};
            s_d.bitIdx = s_q.bitIdx + 5'h01;
            if (s_q.bitIdx == 5'(`FRAME_MSB)) begin
              s_d.strobe = 1'b1;
              s_d.state  = H_LATCH;
            end
          end
        end else begin
          s_d.halfCnt = s_q.halfCnt + 3'h1;
        end
      end
      H_LATCH: begin
        if (s_q.halfCnt == `SCLK_HALF_CYC - 3'h1) begin
          s_d.halfCnt = 3'h0;
          s_d.strobe  = 1'b0;
          s_d.state   = H_IDLE;
        end else begin
          s_d.halfCnt = s_q.halfCnt + 3'h1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q       <= '0;
      s_q.state <= H_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.sclk           = s_q.sclk;
  assign link.sdata          = s_q.frame[`FRAME_MSB];
  assign link.latch_strobe   = s_q.strobe;
  assign link.shutdown_pin_n = s_q.pdnLevel;
  assign rdata               = s_q.rdata;

endmodule
`default_nettype wire

// *** verif/synth_link_checker.sv ***
// Protocol checker for the three-wire synthesizer link
`default_nettype none
module synth_link_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic latch_strobe,
  input wire logic shutdown_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        sclkPrev_q;
  logic        strPrev_q;
  logic [5:0]  bitCnt_q;
  logic [23:0] frame_q;
  // Collects the frame bits seen at each serial clock rise
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclkPrev_q <= 1'b0;
      strPrev_q  <= 1'b0;
      bitCnt_q   <= 6'h00;
      frame_q    <= 24'h000000;
    end else begin
      sclkPrev_q <= sclk;
      strPrev_q  <= latch_strobe;
      if (latch_strobe && !strPrev_q) begin
        bitCnt_q <= 6'h00;
      end else if (sclk && !sclkPrev_q) begin
        bitCnt_q <= bitCnt_q + 6'h01;
        frame_q  <= {frame_q[22:0], sdata};
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_frame_bit_count: assert property ($rose(latch_strobe) |-> bitCnt_q == 6'h18)
    else $error("latch without 24 bits");
  a_ref_reserved_zero: assert property ($rose(latch_strobe) && frame_q[1:0] == 2'h0
    |-> frame_q[23:21] == 3'h0 && frame_q[19:16] == 4'h0) else $error("ref reserved bits set");
  a_cnt_reserved_zero: assert property ($rose(latch_strobe) && frame_q[1:0] == 2'h1
    |-> frame_q[23:22] == 2'h0) else $error("counter reserved bits set");
  a_ref_nonzero: assert property ($rose(latch_strobe) && frame_q[1:0] == 2'h0
    |-> frame_q[15:2] != 14'h0000) else $error("zero reference divider sent");
  a_prog_minimum: assert property ($rose(latch_strobe) && frame_q[1:0] == 2'h1
    |-> frame_q[20:8] >= 13'h0003) else $error("programmable count below 3 sent");
  a_swallow_not_above: assert property ($rose(latch_strobe) && frame_q[1:0] == 2'h1
    |-> frame_q[20:8] >= 13'(frame_q[7:2])) else $error("swallow above programmable count");
  a_strobe_width: assert property ($rose(latch_strobe) |-> latch_strobe[*4] ##1 !latch_strobe)
    else $error("latch strobe width wrong");
  a_sclk_low_latch: assert property (latch_strobe |-> !sclk)
    else $error("serial clock high during latch");
  a_sclk_high_phase: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("serial clock high phase wrong");
  a_data_stable_high: assert property (sclk && $past(sclk) |-> $stable(sdata))
    else $error("serial data moved while clock high");
  c_ref_frame: cover property ($rose(latch_strobe) && frame_q[1:0] == 2'h0);
  c_cnt_frame: cover property ($rose(latch_strobe) && frame_q[1:0] == 2'h1);
  c_fun_frame: cover property ($rose(latch_strobe) && frame_q[1:0] == 2'h2);
  c_latch_while_down: cover property ($rose(latch_strobe) && !shutdown_pin_n);
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Bench joining host and device ends over the link
`include "synth_ctrl_cfg.svh"
`default_nettype none
module tb_top
  import synth_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        rstn;
  logic        compareTick;
  logic        phaseSmall;
  logic        nDivOut;
  logic        rDivOut;
  logic        analogLock;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [13:0] refDivide;
  logic [12:0] progCount;
  logic [5:0]  swallowCount;
  logic [6:0]  prescalerModulus;
  logic [2:0]  pumpCode;
  logic [3:0]  pumpScale;
  logic        dividerClear;
  logic        poweredDown;
  logic        lockDetect;
  logic        lock_out_mux;
  logic        pin;
  logic [31:0] v;
  word_t       badWord [3] = '{22'h0, {3'h0, 13'h2, 6'h0}, {3'h0, 13'h4, 6'h5}};
  logic [1:0]  badCode [3] = '{2'h0, 2'h1, 2'h1};
  logic [2:0]  ldExp [8] = '{3'h0, 3'h0, 3'h4, 3'h7, 3'h2, 3'h1, 3'h0, 3'h0};
  int          bad_count = 0;
  int          samples_checked = 0;
  always #25 core_clk = ~core_clk;
  synth_link_if link ();
  synth_ctrl_host u_synth_ctrl_host (.core_clk(core_clk), .rstn(rstn), .link(link),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  synth_ctrl_device u_synth_ctrl_device (.core_clk(core_clk), .rstn(rstn), .link(link),
    .compareTick(compareTick), .phaseSmall(phaseSmall), .nDivOut(nDivOut),
    .rDivOut(rDivOut), .analogLock(analogLock), .refDivide(refDivide),
    .progCount(progCount), .swallowCount(swallowCount), .prescalerModulus(prescalerModulus),
    .pumpCode(pumpCode), .pumpScale(pumpScale), .dividerClear(dividerClear),
    .poweredDown(poweredDown), .lockDetect(lockDetect), .lock_out_mux(lock_out_mux));
  synth_link_checker u_synth_link_checker (.core_clk(core_clk), .rstn(rstn),
    .sclk(link.sclk), .sdata(link.sdata), .latch_strobe(link.latch_strobe),
    .shutdown_pin_n(link.shutdown_pin_n));
  task automatic end_sim();
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bwr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic brd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask
  task automatic send(input logic [1:0] code, input word_t w);
    logic [31:0] s;
    int n;
    s = 32'h1;
    n = 0;
    bwr(`HOST_DATA, {10'h0, w});
    bwr(`HOST_CMD, (32'h1 << `CMD_GO_BIT) | (32'(pin) << `CMD_PDN_BIT) | 32'(code));
    while (s[`STAT_BUSY_BIT] !== 1'b0 && n < 300) begin
      brd(`HOST_STAT, s);
      n++;
    end
    chk("busy", 32'(s[`STAT_BUSY_BIT]), 32'h0);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic tick(input int n, input logic ph);
    repeat (n) begin
      @(posedge core_clk);
      compareTick <= 1'b1;
      phaseSmall <= ph;
      @(posedge core_clk);
      compareTick <= 1'b0;
    end
    @(negedge core_clk);
  endtask
  function automatic word_t fw(input logic [1:0] pre, input logic ss, input logic [1:0] fa,
                               input logic [2:0] ld, input logic sr, input logic dc);
    return {pre, ss, 3'h5, 3'h2, 4'h1, fa, 2'b00, ld, sr, dc};
  endfunction
  initial begin
    #2000000;
    bad_count++;
    end_sim();
  end
  initial begin
    {rstn, compareTick, phaseSmall, nDivOut, rDivOut, analogLock, wr, rd, pin} = 9'h0;
    addr = 4'h0;
    wdata = 32'h0;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    chk("powered", 32'(poweredDown), 32'h1);
    chk("scale", 32'(pumpScale), 32'h1);
    send(`ADDR_REF, {3'h7, 1'b0, 4'hf, 14'h3fff});
    chk("refdiv", 32'(refDivide), 32'h3fff);
    brd(4'hc, v);
    chk("unmapped", v, 32'h0);
    for (int i = 0; i < 4; i++) begin
      send(`ADDR_FUN, fw(2'(i), 1'b0, 2'h0, `LD_HIGH, 1'b0, i[0]));
      chk("modulus", 32'(prescalerModulus), 32'(8 << i));
      chk("clear", 32'(dividerClear), 32'(i[0]));
    end
    pin = 1'b1;
    send(`ADDR_FUN, fw(2'h0, 1'b0, 2'h0, `LD_DIGITAL, 1'b0, 1'b0));
    chk("powered", 32'(poweredDown), 32'h0);
    send(`ADDR_CNT, {3'h0, 13'h3, 6'h3});
    chk("prog", 32'(progCount), 32'h3);
    chk("swallow", 32'(swallowCount), 32'h3);
    chk("pump", 32'(pumpCode), 32'h2);
    send(`ADDR_CNT, {3'h1, 13'h1fff, 6'h3f});
    chk("pump", 32'(pumpCode), 32'h5);
    chk("scale", 32'(pumpScale), 32'h6);
    for (int i = 0; i < 3; i++) begin
      send(badCode[i], badWord[i]);
      brd(`HOST_STAT, v);
      chk("error", 32'(v[`STAT_ERR_BIT]), 32'h1);
      bwr(`HOST_STAT, 32'h2);
      brd(`HOST_STAT, v);
      chk("error", 32'(v[`STAT_ERR_BIT]), 32'h0);
      chk("prog", 32'(progCount), 32'h1fff);
    end
    send(`ADDR_FUN, fw(2'h0, 1'b0, `FAST_ON, `LD_DIGITAL, 1'b0, 1'b0));
    send(`ADDR_CNT, {3'h1, 13'h8, 6'h0});
    chk("pump", 32'(pumpCode), 32'h5);
    tick(6, 1'b0);
    chk("pump", 32'(pumpCode), 32'h5);
    tick(1, 1'b0);
    chk("pump", 32'(pumpCode), 32'h2);
    for (int d = 0; d < 2; d++) begin
      send(`ADDR_REF, {3'h0, d[0], 4'h0, 14'h1});
      send(`ADDR_CNT, {3'h0, 13'h8, 6'h0});
      tick(d ? 30 : 14, 1'b1);
      chk("lock", 32'(lockDetect), 32'h0);
      tick(1, 1'b1);
      chk("lock", 32'(lockDetect), 32'h1);
      @(posedge core_clk);
      @(negedge core_clk);
      chk("lockpin", 32'(lock_out_mux), 32'h1);
      tick(d ? 6 : 2, 1'b0);
      chk("lock", 32'(lockDetect), 32'h1);
      tick(1, 1'b0);
      chk("lock", 32'(lockDetect), 32'h0);
    end
    send(2'h3, 22'h3fffff);
    chk("refdiv", 32'(refDivide), 32'h1);
    chk("prog", 32'(progCount), 32'h8);
    for (int m = 0; m < 8; m++) begin
      send(`ADDR_FUN, fw(2'h0, 1'b0, 2'h0, 3'(m), 1'b0, 1'b0));
      for (int k = 0; k < 3; k++) begin
        @(posedge core_clk);
        {nDivOut, rDivOut, analogLock} <= 3'(3'h1 << k);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk("lockpin", 32'(lock_out_mux), 32'(ldExp[m][k]));
      end
    end
    send(`ADDR_FUN, fw(2'h0, 1'b0, 2'h0, `LD_DIGITAL, 1'b1, 1'b0));
    chk("powered", 32'(poweredDown), 32'h1);
    send(`ADDR_FUN, fw(2'h0, 1'b1, 2'h0, `LD_DIGITAL, 1'b0, 1'b0));
    chk("powered", 32'(poweredDown), 32'h0);
    send(`ADDR_FUN, fw(2'h0, 1'b1, 2'h0, `LD_DIGITAL, 1'b1, 1'b0));
    chk("powered", 32'(poweredDown), 32'h0);
    tick(1, 1'b0);
    @(posedge core_clk);
    @(negedge core_clk);
    chk("powered", 32'(poweredDown), 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
